//--- design/cis_sequencer.sv
// Counter and interrupt sequencer: recovery timing plus interrupt entry and return.
// Assumes the CPU core flags instruction boundaries and opcodes for one cycle each.
// Operation
// [RULE1] Twelve-bit recovery counter advances on each falling reference clock edge.
// [RULE2] Counter overflow clocks the watchdog module.
// [RULE3] Bus clocks stay off after power-on and stop until delay elapses.
// [RULE4] Stop instruction clears the recovery counter.
// [RULE5] Stop exit by interrupt uses 32 cycles when short recovery selected.
// [RULE6] Counter runs freely, wrapping, after reset states.
// [RULE7] Power-on pulse resets the unit; then the clock generator is enabled.
// [RULE8] Entry stacks CPU registers, then sets the interrupt mask.
// [RULE9] Return instruction restores registers from stack and resumes.
// [RULE10] Requests are latched and arbitrated when interrupt processing starts.
// [RULE11] Arbitration result is a constant selecting the vector fetched.
// [RULE12] Latched interrupt is not preempted until serviced or mask cleared.
// [RULE13] Hardware interrupts never abort an instruction; checked at boundaries.
// [RULE14] Take interrupt only with mask clear and source enabled.
// [RULE15] Highest-priority pending request is serviced first.
// [RULE16] Request pending at return is entered before the prefetched instruction.
// [RULE17] Index high register is never stacked.
// [RULE18] Software interrupt is taken regardless of the mask.
// [RULE19] Software interrupt stacks PC; hardware interrupt stacks PC minus one.
// [RULE20] Entry: dummy cycle, descending stack writes, vector high then low.
// [RULE21] Write to top location clears watchdog and counter stages 12 to 5.
// [RULE22] Stop exit by reset always uses the 4096-cycle delay.
`timescale 1ns/1ps
module cis_sequencer
    import cis_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic powerOnResetPulse,
    input wire logic clockGenRefFall,
    input wire logic shortRecoverySelect,
    input wire logic stopInstr,
    input wire logic stopWakeReset,
    input wire logic watchdogServiceWrite,
    input wire logic instrBoundary,
    input wire logic softwareInterruptInstr,
    input wire logic returnFromInterruptInstr,
    input wire logic [15:0] irqRequest,
    input wire logic [15:0] irqEnable,
    input wire logic maskBit,
    input wire logic [15:0] cpuPc,
    input wire logic [7:0] cpuSp,
    input wire logic [7:0] cpuAcc,
    input wire logic [7:0] cpuIndexLow,
    input wire logic [7:0] cpuCcr,
    output logic internalBusClocksEn,
    output logic clockGenEn,
    output logic watchdogClock,
    output logic watchdogClear,
    output logic setMask,
    output logic [4:0] vectorSelect,
    output logic vectorHighFetch,
    output logic vectorLowFetch,
    output logic dummyCycle,
    output logic stackWrite,
    output logic stackRead,
    output logic [7:0] stackAddr,
    output logic [7:0] stackData,
    output logic cpuHold,
    output logic resumeExec
);
    typedef struct packed {
        cis_pwr_e pwr;
        logic [11:0] target;
        cis_seq_e seq;
        logic [2:0] idx;
        logic [4:0] vec;
        logic [15:0] pcStack;
        logic [7:0] sp;
        logic busEn;
        logic cgEn;
        logic wdClk;
        logic wdClr;
        logic setI;
        logic vh;
        logic vl;
        logic dmy;
        logic sw;
        logic sr;
        logic [7:0] addr;
        logic [7:0] data;
        logic hold;
        logic resume;
    } cis_state_s;

    cis_state_s st_q, st_d;
    logic [11:0] count;
    logic ovf;
    logic cntClr;
    logic arbAny;
    logic [4:0] arbCode;

    // Only the byte order of the stack frame is fixed here: PC low, PC high, X, A, CCR.
    function automatic logic [7:0] stackByte(input logic [2:0] n, input cis_state_s s);
        unique case (n)
            3'h0: stackByte = s.pcStack[7:0];
            3'h1: stackByte = s.pcStack[15:8];
            3'h2: stackByte = cpuIndexLow;
            3'h3: stackByte = cpuAcc;
            default: stackByte = cpuCcr;
        endcase
    endfunction

    cis_recovery_counter u_counter (
        .clock(clock),
        .rst(rst | powerOnResetPulse),
        .refFall(clockGenRefFall),
        .clearAll(cntClr),
        .clearHigh(watchdogServiceWrite),
        .count(count),
        .overflow(ovf)
    );

    cis_arbiter u_arbiter (
        .pending(irqRequest & irqEnable), // [RULE14]
        .any(arbAny),
        .code(arbCode)
    );

    assign cntClr = (st_q.pwr == CIS_PWR_RUN) && stopInstr; // [RULE4]

    always_comb begin
        st_d = st_q;
        st_d.wdClk = ovf; // [RULE2]
        st_d.wdClr = watchdogServiceWrite; // [RULE21]
        st_d.setI = 1'b0;
        st_d.vh = 1'b0;
        st_d.vl = 1'b0;
        st_d.dmy = 1'b0;
        st_d.sw = 1'b0;
        st_d.sr = 1'b0;
        st_d.resume = 1'b0;
        unique case (st_q.pwr)
            CIS_PWR_HOLD: begin
                st_d.cgEn = 1'b1; // [RULE7]
                if (count == st_q.target) begin
                    st_d.pwr = CIS_PWR_RUN; // [RULE3]
                    st_d.busEn = 1'b1;
                end
            end
            CIS_PWR_RUN: begin
                if (stopInstr) begin
                    st_d.pwr = CIS_PWR_STOP;
                    st_d.busEn = 1'b0;
                end
            end
            CIS_PWR_STOP: begin
                if (stopWakeReset) begin
                    st_d.target = CIS_LONG_DELAY; // [RULE22]
                    st_d.pwr = CIS_PWR_HOLD;
                end else if (arbAny) begin
                    st_d.target = shortRecoverySelect ? CIS_SHORT_DELAY : CIS_LONG_DELAY; // [RULE5]
                    st_d.pwr = CIS_PWR_HOLD;
                end
            end
        endcase
        st_d.hold = (st_d.pwr != CIS_PWR_RUN) || (st_d.seq != CIS_RUN);
        unique case (st_q.seq)
            CIS_RUN: begin
                if (st_q.pwr == CIS_PWR_RUN && softwareInterruptInstr) begin
                    st_d.vec = CIS_SWI_CODE; // [RULE18]
                    st_d.pcStack = cpuPc; // [RULE19]
                    st_d.seq = CIS_DUMMY;
                end else if (st_q.pwr == CIS_PWR_RUN && instrBoundary && !maskBit && arbAny) begin
                    st_d.vec = arbCode; // [RULE10] [RULE13]
                    st_d.pcStack = cpuPc - CIS_PC_ONE; // [RULE19]
                    st_d.seq = CIS_DUMMY;
                end else if (st_q.pwr == CIS_PWR_RUN && returnFromInterruptInstr) begin
                    st_d.seq = CIS_PULL; // [RULE9]
                    st_d.idx = CIS_PUSH_ZERO;
                    st_d.sp = cpuSp;
                end
                st_d.hold = (st_d.pwr != CIS_PWR_RUN) || (st_d.seq != CIS_RUN);
            end
            CIS_DUMMY: begin
                st_d.dmy = 1'b1; // [RULE20]
                st_d.idx = CIS_PUSH_ZERO;
                st_d.sp = cpuSp;
                st_d.seq = CIS_PUSH;
            end
            CIS_PUSH: begin
                st_d.sw = 1'b1; // [RULE8] [RULE17]
                st_d.addr = st_q.sp;
                st_d.data = stackByte(st_q.idx, st_q);
                st_d.sp = st_q.sp - CIS_SP_ONE; // [RULE20]
                st_d.idx = st_q.idx + 3'h1;
                if (st_q.idx == CIS_NUM_PUSH) begin
                    st_d.seq = CIS_VECH;
                end
            end
            CIS_VECH: begin
                st_d.vh = 1'b1; // [RULE11] [RULE12]
                st_d.setI = 1'b1; // [RULE8]
                st_d.seq = CIS_VECL;
            end
            CIS_VECL: begin
                st_d.vl = 1'b1;
                st_d.seq = CIS_RUN;
                st_d.resume = 1'b1;
            end
            CIS_PULL: begin
                st_d.sr = 1'b1;
                st_d.sp = st_q.sp + CIS_SP_ONE;
                st_d.addr = st_q.sp + CIS_SP_ONE;
                st_d.idx = st_q.idx + 3'h1;
                if (st_q.idx == CIS_NUM_PUSH) begin
                    // A request waiting here is entered before the prefetched opcode runs.
                    if (arbAny && !cpuCcr[3]) begin
                        st_d.vec = arbCode; // [RULE16]
                        st_d.pcStack = cpuPc - CIS_PC_ONE;
                        st_d.seq = CIS_DUMMY;
                    end else begin
                        st_d.seq = CIS_RUN;
                        st_d.resume = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst || powerOnResetPulse) begin
            st_q <= '0;
            st_q.pwr <= CIS_PWR_HOLD;
            st_q.seq <= CIS_RUN;
            st_q.target <= CIS_LONG_DELAY;
            st_q.hold <= 1'b1;
            st_q.vec <= CIS_NONE_CODE;
        end else begin
            st_q <= st_d;
        end
    end

    assign internalBusClocksEn = st_q.busEn;
    assign clockGenEn = st_q.cgEn;
    assign watchdogClock = st_q.wdClk;
    assign watchdogClear = st_q.wdClr;
    assign setMask = st_q.setI;
    assign vectorSelect = st_q.vec;
    assign vectorHighFetch = st_q.vh;
    assign vectorLowFetch = st_q.vl;
    assign dummyCycle = st_q.dmy;
    assign stackWrite = st_q.sw;
    assign stackRead = st_q.sr;
    assign stackAddr = st_q.addr;
    assign stackData = st_q.data;
    assign cpuHold = st_q.hold;
    assign resumeExec = st_q.resume;
endmodule // cis_sequencer

//--- design/cis_pkg.sv
// Package of constants, types and states for the counter and interrupt sequencer.
// Assumes one clock domain and a synchronous active-high reset.
package cis_pkg;
    localparam int CIS_CNT_W = 12;
    localparam int CIS_NSRC = 16;
    localparam int CIS_SRC_W = 5;
    localparam logic [11:0] CIS_LONG_DELAY = 12'hfff;
    localparam logic [11:0] CIS_SHORT_DELAY = 12'h01f;
    localparam logic [11:0] CIS_ZERO = 12'h000;
    localparam logic [11:0] CIS_HIGH_CLR_MASK = 12'h00f;
    localparam logic [11:0] CIS_ONE = 12'h001;
    localparam logic [15:0] CIS_PC_ONE = 16'h0001;
    localparam logic [7:0] CIS_SP_ONE = 8'h01;
    localparam logic [4:0] CIS_SWI_CODE = 5'h00;
    localparam logic [4:0] CIS_NONE_CODE = 5'h1f;
    localparam logic [2:0] CIS_NUM_PUSH = 3'h4;
    localparam logic [2:0] CIS_PUSH_ZERO = 3'h0;

    typedef enum logic [5:0] {
        CIS_RUN = 6'b000001,
        CIS_DUMMY = 6'b000010,
        CIS_PUSH = 6'b000100,
        CIS_VECH = 6'b001000,
        CIS_VECL = 6'b010000,
        CIS_PULL = 6'b100000
    } cis_seq_e;

    typedef enum logic [2:0] {
        CIS_PWR_HOLD = 3'b001,
        CIS_PWR_RUN = 3'b010,
        CIS_PWR_STOP = 3'b100
    } cis_pwr_e;
endpackage

//--- design/cis_recovery_counter.sv
// Twelve-bit recovery counter, timing power-on and stop recovery.
// Assumes the reference clock enable pulse marks a falling reference edge.
`timescale 1ns/1ps
module cis_recovery_counter
    import cis_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic refFall,
    input wire logic clearAll,
    input wire logic clearHigh,
    output logic [11:0] count,
    output logic overflow
);
    typedef struct packed {
        logic [11:0] cnt;
        logic ovf;
    } cis_cnt_s;

    cis_cnt_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.ovf = 1'b0;
        if (clearAll) begin
            st_d.cnt = CIS_ZERO; // [RULE4]
        end else if (clearHigh) begin
            st_d.cnt = st_q.cnt & CIS_HIGH_CLR_MASK; // [RULE21]
        end else if (refFall) begin
            st_d.cnt = st_q.cnt + CIS_ONE; // [RULE1] [RULE6]
            st_d.ovf = (st_q.cnt == CIS_LONG_DELAY); // [RULE2]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
    assign overflow = st_q.ovf;
endmodule // cis_recovery_counter

//--- design/cis_arbiter.sv
// Fixed-priority arbiter: lowest index wins among enabled pending requests.
// Assumes requests are levels held by the sources until serviced.
`timescale 1ns/1ps
module cis_arbiter
    import cis_pkg::*;
(
    input wire logic [15:0] pending,
    output logic any,
    output logic [4:0] code
);
    always_comb begin
        any = 1'b0;
        code = CIS_NONE_CODE;
        for (int i = CIS_NSRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                any = 1'b1;
                code = 5'(i + 1); // [RULE15]
            end
        end
    end
endmodule // cis_arbiter

//--- test/cis_sequencer_sva.sv
// Port assertions for the counter and interrupt sequencer.
// Assumes it is bound into cis_sequencer and shares its clock and reset.
`timescale 1ns/1ps
module cis_sequencer_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic powerOnResetPulse,
    input wire logic instrBoundary,
    input wire logic softwareInterruptInstr,
    input wire logic returnFromInterruptInstr,
    input wire logic [15:0] irqRequest,
    input wire logic [15:0] irqEnable,
    input wire logic maskBit,
    input wire logic stopInstr,
    input wire logic watchdogServiceWrite,
    input wire logic internalBusClocksEn,
    input wire logic watchdogClear,
    input wire logic setMask,
    input wire logic vectorHighFetch,
    input wire logic vectorLowFetch,
    input wire logic dummyCycle,
    input wire logic stackWrite,
    input wire logic stackRead,
    input wire logic [7:0] stackAddr,
    input wire logic cpuHold,
    input wire logic resumeExec
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst || powerOnResetPulse);
    wire hwReq = |(irqRequest & irqEnable);
    wire idle = internalBusClocksEn && !cpuHold && !returnFromInterruptInstr;
    // A return loses to a software or hardware entry taken in the same cycle.
    wire rtiGo = internalBusClocksEn && !cpuHold && returnFromInterruptInstr &&
        !softwareInterruptInstr && !(instrBoundary && !maskBit && hwReq);
    // The take edge loads the sequence state and the next edge registers its first pulse,
    // so the first step of a sequence is seen two samples after the take.
    sequence s_push; stackWrite [*5]; endsequence
    sequence s_vec; vectorHighFetch && setMask ##1 vectorLowFetch && resumeExec; endsequence
    property p_take; idle && instrBoundary && !maskBit && hwReq |=> ##1 dummyCycle; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_entry; dummyCycle |=> s_push ##1 s_vec; endproperty
    a_entry: assert property (p_entry) else $error("entry steps out of order");
    property p_desc; stackWrite && $past(stackWrite) |-> stackAddr == $past(stackAddr) - 8'h01;
    endproperty
    a_desc: assert property (p_desc) else $error("stack address not descending");
    property p_mask; idle && !softwareInterruptInstr && (maskBit || !hwReq) |=> ##1 !dummyCycle;
    endproperty
    a_mask: assert property (p_mask) else $error("entry without cause");
    property p_swi; idle && softwareInterruptInstr |=> ##1 dummyCycle; endproperty
    a_swi: assert property (p_swi) else $error("software interrupt not taken");
    property p_rti; rtiGo |=> ##1 stackRead [*5]; endproperty
    a_rti: assert property (p_rti) else $error("return did not read five bytes");
    property p_wdog; watchdogServiceWrite |=> watchdogClear; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
    property p_stop; stopInstr && internalBusClocksEn && !cpuHold |=> ##[0:1] !internalBusClocksEn;
    endproperty
    a_stop: assert property (p_stop) else $error("bus clocks kept in stop");
endmodule // cis_sequencer_sva
bind cis_sequencer cis_sequencer_sva cis_sequencer_sva_i (.*);

//--- test/cis_cpu_model.sv
// CPU core stand-in: flags instruction ends and records the stacked bytes.
// Assumes the sequencer writes at most one stack byte per cycle.
`timescale 1ns/1ps
module cis_cpu_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic internalBusClocksEn,
    input wire logic cpuHold,
    input wire logic stackWrite,
    input wire logic [7:0] stackAddr,
    input wire logic [7:0] stackData,
    output logic instrBoundary
);
    logic [7:0] mem [256];
    logic [1:0] phase = 2'h0;
    initial instrBoundary = 1'b0;
    // Instructions stall while held, so no boundary lands inside a sequence.
    always @(posedge clock) begin
        if (rst) begin
            foreach (mem[i]) mem[i] <= 8'h5a;
        end
        if (stackWrite === 1'b1) mem[stackAddr] <= stackData;
        if (run && internalBusClocksEn && !cpuHold) phase <= phase + 2'h1;
        instrBoundary <= #1 run && internalBusClocksEn && !cpuHold && phase == 2'h3;
    end
endmodule // cis_cpu_model

//--- test/tb_top.sv
// Self-checking bench for the counter and interrupt sequencer.
// Assumes the CPU stand-in model and the bound checker.
`timescale 1ns/1ps
module tb_top import cis_pkg::*;;
    typedef struct packed {
        logic [15:0] rq;
        logic [15:0] ena;
        logic msk;
        logic sw;
        logic [4:0] code;
    } cis_row_s;
    localparam cis_row_s ROWS [6] = '{
        '{16'h0006, 16'hffff, 1'b0, 1'b0, 5'h02},
        '{16'h8000, 16'hffff, 1'b0, 1'b0, 5'h10},
        '{16'h0003, 16'h0002, 1'b0, 1'b0, 5'h02},
        '{16'h0001, 16'h0000, 1'b0, 1'b0, 5'h1f},
        '{16'h0001, 16'hffff, 1'b1, 1'b0, 5'h1f},
        '{16'h0001, 16'hffff, 1'b1, 1'b1, 5'h00}};
    logic clock = 1'b0, rst = 1'b1, run = 1'b1, powerOnResetPulse = 1'b0;
    logic clockGenRefFall = 1'b0, shortRecoverySelect = 1'b0, stopInstr = 1'b0;
    logic stopWakeReset = 1'b0, watchdogServiceWrite = 1'b0, maskBit = 1'b0;
    logic softwareInterruptInstr = 1'b0, returnFromInterruptInstr = 1'b0;
    logic [15:0] irqRequest = 16'h0000, irqEnable = 16'hffff, cpuPc = 16'h1234;
    logic [7:0] cpuSp = 8'hf0, cpuAcc = 8'h41, cpuIndexLow = 8'h58, cpuCcr = 8'h00;
    logic instrBoundary, internalBusClocksEn, clockGenEn, watchdogClock, watchdogClear;
    logic setMask, vectorHighFetch, vectorLowFetch, dummyCycle, stackWrite, stackRead;
    logic cpuHold, resumeExec;
    logic [4:0] vectorSelect;
    logic [7:0] stackAddr, stackData;
    int fails = 0, checked = 0, cycles = 0, nDum = 0, nWd = 0, nRd = 0, nClr = 0, d0;
    cis_sequencer cis_sequencer_i (.*);
    cis_cpu_model cis_cpu_model_i (.*);
    always #20 clock = ~clock;
    // Every source drops its request once a dummy cycle is seen, as serviced peripherals would.
    always @(posedge clock) begin
        cycles++;
        nDum += int'(dummyCycle === 1'b1);
        nWd += int'(watchdogClock === 1'b1);
        nRd += int'(stackRead === 1'b1);
        nClr += int'(watchdogClear === 1'b1);
        if (dummyCycle === 1'b1) irqRequest <= 16'h0000;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic refs(input int n);
        clockGenRefFall = 1'b1;
        cyc(n);
        clockGenRefFall = 1'b0;
    endtask
    task automatic bus(input string nm, input logic e);
        cyc(2);
        chk(nm, 16'(internalBusClocksEn), 16'(e));
    endtask
    task automatic return_from_interrupt_instr;
        returnFromInterruptInstr = 1'b1;
        cyc(1);
        returnFromInterruptInstr = 1'b0;
        cyc(16);
    endtask
    task automatic stopNow;
        stopInstr = 1'b1;
        cyc(1);
        stopInstr = 1'b0;
        bus("stopOff", 1'b0);
        chk("stopClear", 16'(cis_sequencer_i.u_counter.count), 16'h0000);
    endtask
    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(20);
        chk("busReset", 16'(internalBusClocksEn), 16'h0000);
        chk("holdReset", 16'(cpuHold), 16'h0001);
        chk("vecReset", 16'(vectorSelect), 16'(CIS_NONE_CODE));
        rst = 1'b0;
        cyc(2);
        chk("clockGenEn", 16'(clockGenEn), 16'h0001);
        refs(4094);
        bus("busEarly", 1'b0);
        refs(1);
        bus("busOn", 1'b1);
        d0 = nWd;
        refs(1);
        cyc(3);
        chk("wdClock", 16'(nWd - d0), 16'h0001);
        foreach (ROWS[i]) begin
            irqRequest = ROWS[i].rq;
            irqEnable = ROWS[i].ena;
            maskBit = ROWS[i].msk;
            softwareInterruptInstr = ROWS[i].sw;
            d0 = nDum;
            cyc(1);
            softwareInterruptInstr = 1'b0;
            cyc(14);
            chk("taken", 16'(nDum - d0), 16'(ROWS[i].code != CIS_NONE_CODE));
            if (ROWS[i].code != CIS_NONE_CODE) begin
                chk("vector", 16'(vectorSelect), 16'(ROWS[i].code));
                chk("pcLow", 16'(cis_cpu_model_i.mem[cpuSp]), ROWS[i].sw ? 16'h0034 : 16'h0033);
                chk("noIndexHigh", 16'(cis_cpu_model_i.mem[cpuSp - 8'h05]), 16'h005a);
            end
        end
        run = 1'b0;
        maskBit = 1'b0;
        irqRequest = 16'h0000;
        d0 = nRd;
        return_from_interrupt_instr();
        chk("rtiReads", 16'(nRd - d0), 16'h0005);
        irqRequest = 16'h0010;
        d0 = nDum;
        return_from_interrupt_instr();
        chk("rtiPending", 16'(nDum - d0), 16'h0001);
        chk("rtiVector", 16'(vectorSelect), 16'h0005);
        run = 1'b1;
        // The counter sits at zero after its wrap; twenty falls set bits in both halves.
        refs(20);
        d0 = nClr;
        watchdogServiceWrite = 1'b1;
        cyc(1);
        watchdogServiceWrite = 1'b0;
        cyc(2);
        chk("wdClear", 16'(nClr - d0), 16'h0001);
        chk("cntLowKept", 16'(cis_sequencer_i.u_counter.count), 16'h0004);
        stopNow();
        shortRecoverySelect = 1'b1;
        irqRequest = 16'h0004;
        cyc(2);
        refs(30);
        bus("shortEarly", 1'b0);
        refs(1);
        bus("shortOn", 1'b1);
        cyc(14);
        stopNow();
        stopWakeReset = 1'b1;
        cyc(1);
        stopWakeReset = 1'b0;
        refs(31);
        bus("resetWakeEarly", 1'b0);
        refs(4064);
        bus("resetWakeOn", 1'b1);
        powerOnResetPulse = 1'b1;
        cyc(1);
        powerOnResetPulse = 1'b0;
        chk("porOff", 16'(internalBusClocksEn), 16'h0000);
        stop_test();
    end
endmodule // tb_top
